// [rtl/nthr_regs.sv]
// Tag response parameter registers with APB slave and response sequencer
//
// How it works
// - Update command loads buffer start with index
// - Late answer sends extension; timeout restarts on ack
// - Extension byte from low byte, resets one
// - Default status words generated automatically
// - Custom enable selects custom status word register
// - Upper byte is SW1, lower is SW2
// - Version register readable by software
// - Custom enable is host response bit two
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "nthr_params.svh"

module nthr_regs
    import nthr_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [19:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire nthr_cmd_type    cmd,
    input  wire nthr_answer_type answer,
    input  wire logic            wtx_ack,
    input  wire logic [19:0]     fwt_limit,
    output nthr_resp_type        resp,
    output nthr_wtx_type         wtx,
    output logic      [15:0]     buffer_start
);

    // Index match, used by every read and write decode
    function automatic logic idx_hit(input logic [17:0] a, input logic [15:0] i);
        idx_hit = (a == {2'b00, i});
    endfunction

    // Stored registers
    logic [15:0]    custom_status_word;   // Custom SW1/SW2 pair
    logic [15:0]    wait_extension_value; // Extension byte plus reserved byte
    logic [7:0]     host_response;        // Host response control bits
    nthr_state_type state;                // Sequencer state
    nthr_state_type next_state;           // Sequencer next state

    // Bus decode
    logic [17:0] idx;           // Word index of the access
    logic        aligned;       // Word aligned address
    logic        setup;         // Setup phase of a transfer
    logic        wr_done;       // Write completing at this edge
    logic        rd_hit;        // Address maps to a register
    logic [7:0]  rd_byte;       // Read value of the addressed register
    logic [7:0]  status_byte;   // Live sequencer state for software
    logic        custom_enable; // Custom status enable bit
    logic        wtx_due;       // Frame wait timer asks for an extension
    logic        answer_take;   // Host answer accepted
    logic        load_index;    // Update command stores its packet index
    logic [15:0] chosen_sw;     // Status word sent to the reader
    logic        fwt_run;       // Frame wait timer counts only while waiting

    assign idx     = paddr[19:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup   = psel & ~penable;
    // Writes land only at the edge that completes the access phase
    assign wr_done = psel & penable & pready & pwrite & aligned & ~pslverr;

    // Each printed byte is its own index; pairs form 16-bit values
    assign rd_hit = aligned & (idx_hit(idx, `NTHR_IDX_CSW_LO)
                  | idx_hit(idx, `NTHR_IDX_CSW_HI) | idx_hit(idx, `NTHR_IDX_WTX_LO)
                  | idx_hit(idx, `NTHR_IDX_WTX_HI) | idx_hit(idx, `NTHR_IDX_BUF_LO)
                  | idx_hit(idx, `NTHR_IDX_BUF_HI) | idx_hit(idx, `NTHR_IDX_HOST_RESP)
                  | idx_hit(idx, `NTHR_IDX_VER_LO) | idx_hit(idx, `NTHR_IDX_VER_HI)
                  | idx_hit(idx, `NTHR_IDX_STATUS));

    // Status shows sequencer state and a pending extension
    assign status_byte = {5'b00000, wtx.valid, state};

    // Read selection; the version pair is a constant
    assign rd_byte =
        idx_hit(idx, `NTHR_IDX_CSW_LO)    ? custom_status_word[7:0]   :
        idx_hit(idx, `NTHR_IDX_CSW_HI)    ? custom_status_word[15:8]  :
        idx_hit(idx, `NTHR_IDX_WTX_LO)    ? wait_extension_value[7:0] :
        idx_hit(idx, `NTHR_IDX_WTX_HI)    ? wait_extension_value[15:8] :
        idx_hit(idx, `NTHR_IDX_BUF_LO)    ? buffer_start[7:0]         :
        idx_hit(idx, `NTHR_IDX_BUF_HI)    ? buffer_start[15:8]        :
        idx_hit(idx, `NTHR_IDX_HOST_RESP) ? host_response             :
        idx_hit(idx, `NTHR_IDX_VER_LO)    ? 8'(`NTHR_VERSION)         :
        idx_hit(idx, `NTHR_IDX_VER_HI)    ? 8'(`NTHR_VERSION >> 8)    :
        idx_hit(idx, `NTHR_IDX_STATUS)    ? status_byte               :
        8'h00;

    // Custom enable sits at bit two of host response
    assign custom_enable = host_response[`NTHR_BIT_CUSTOM_EN];

    // Custom word replaces the predefined one when enabled
    assign chosen_sw = custom_enable ? custom_status_word :
                       (answer.ok ? `NTHR_SW_OK : `NTHR_SW_FAIL);

    assign answer_take = answer.valid & (state != NTHR_ST_IDLE);
    assign load_index  = cmd.valid & (state == NTHR_ST_IDLE) & (cmd.kind == NTHR_CMD_UPDATE);
    assign fwt_run     = (state == NTHR_ST_WAIT);

    // APB handshake: no wait state; read data comes from a flop loaded in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~rd_hit;
            if (setup)
            begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

    // Custom status word bytes, written by software only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            custom_status_word <= `NTHR_RST_CSW;
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_CSW_LO))
        begin
            custom_status_word[7:0] <= pwdata[7:0];
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_CSW_HI))
        begin
            custom_status_word[15:8] <= pwdata[7:0];
        end
    end

    // Extension register; the upper byte is stored as written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_extension_value <= `NTHR_RST_WTX;
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_WTX_LO))
        begin
            wait_extension_value[7:0] <= pwdata[7:0];
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_WTX_HI))
        begin
            wait_extension_value[15:8] <= pwdata[7:0];
        end
    end

    // Buffer start: the hardware load wins over a same-cycle host write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buffer_start <= `NTHR_RST_BUF;
        end
        else if (load_index)
        begin
            buffer_start <= cmd.store_index;
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_BUF_LO))
        begin
            buffer_start[7:0] <= pwdata[7:0];
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_BUF_HI))
        begin
            buffer_start[15:8] <= pwdata[7:0];
        end
    end

    // Host response control bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_response <= `NTHR_RST_HOST_RESP;
        end
        else if (wr_done && idx_hit(idx, `NTHR_IDX_HOST_RESP))
        begin
            host_response <= pwdata[7:0];
        end
    end

    // Frame wait timer runs only while an answer is outstanding
    nthr_fwt u_fwt (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (fwt_run),
        .limit   (fwt_limit),
        .due     (wtx_due)
    );

    // Sequencer next state; an answer always beats a due extension
    always_comb
    begin
        next_state = state;
        case (state)
            NTHR_ST_IDLE:
            begin
                if (cmd.valid)
                begin
                    next_state = NTHR_ST_WAIT;
                end
            end
            NTHR_ST_WAIT:
            begin
                if (answer.valid)
                begin
                    next_state = NTHR_ST_IDLE;
                end
                else if (wtx_due)
                begin
                    next_state = NTHR_ST_WTX;
                end
            end
            NTHR_ST_WTX:
            begin
                // Leaving this state restarts the timer from zero
                if (answer.valid)
                begin
                    next_state = NTHR_ST_IDLE;
                end
                else if (wtx_ack)
                begin
                    next_state = NTHR_ST_WAIT;
                end
            end
            default:
            begin
                next_state = NTHR_ST_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= NTHR_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Status word pulse towards the reader
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resp <= '0;
        end
        else
        begin
            resp.valid <= answer_take;
            if (answer_take)
            begin
                resp.sw1 <= chosen_sw[15:8];
                resp.sw2 <= chosen_sw[7:0];
            end
        end
    end

    // Extension request stands until the reader acknowledges it or the host answer arrives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wtx <= '0;
        end
        else if (state == NTHR_ST_WAIT && next_state == NTHR_ST_WTX)
        begin
            wtx.valid               <= 1'b1;
            wtx.wait_extension_byte <= wait_extension_value[7:0];
        end
        else if (next_state != NTHR_ST_WTX)
        begin
            wtx.valid <= 1'b0;
        end
    end

endmodule

// [pkg/nthr_params.svh]
// Offsets, reset values and timing constants of the tag response parameter block
`ifndef NTHR_PARAMS_SVH
`define NTHR_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define NTHR_IDX_CSW_LO    16'hffda
`define NTHR_IDX_CSW_HI    16'hffdb
`define NTHR_IDX_WTX_LO    16'hffde
`define NTHR_IDX_WTX_HI    16'hffdf
`define NTHR_IDX_BUF_LO    16'hffe4
`define NTHR_IDX_BUF_HI    16'hffe5
`define NTHR_IDX_HOST_RESP 16'hffc0
`define NTHR_IDX_VER_LO    16'hffc2
`define NTHR_IDX_VER_HI    16'hffc3
`define NTHR_IDX_STATUS    16'hffc4

// Field positions
`define NTHR_BIT_CUSTOM_EN 2

// Reset values
`define NTHR_RST_CSW       16'h0000
`define NTHR_RST_WTX       16'h0001
`define NTHR_RST_BUF       16'h0000
`define NTHR_RST_HOST_RESP 8'h00

// Software version, value is arbitrary
`define NTHR_VERSION       16'h0100

// Predefined status words for success and for failure
`define NTHR_SW_OK         16'h9000
`define NTHR_SW_FAIL       16'h6a82

// Cycles before the frame wait limit at which an extension is asked for
`define NTHR_WTX_MARGIN    20'h00010

`endif

// [pkg/nthr_pkg.sv]
// Types shared by the tag response parameter block
package nthr_pkg;

    // Reader command kinds
    typedef enum logic [1:0] {
        NTHR_CMD_SELECT = 2'b00,
        NTHR_CMD_READ   = 2'b01,
        NTHR_CMD_UPDATE = 2'b10
    } nthr_kind_type;

    // Sequencer states
    typedef enum logic [1:0] {
        NTHR_ST_IDLE = 2'b00,
        NTHR_ST_WAIT = 2'b01,
        NTHR_ST_WTX  = 2'b10
    } nthr_state_type;

    // Reader command as handed over by the radio side
    typedef struct packed {
        logic          valid;
        nthr_kind_type kind;
        logic [15:0]   store_index;
    } nthr_cmd_type;

    // Outcome of the host handling the command
    typedef struct packed {
        logic valid;
        logic ok;
    } nthr_answer_type;

    // Status word sent back to the reader
    typedef struct packed {
        logic       valid;
        logic [7:0] sw1;
        logic [7:0] sw2;
    } nthr_resp_type;

    // Wait time extension request towards the reader
    typedef struct packed {
        logic       valid;
        logic [7:0] wait_extension_byte;
    } nthr_wtx_type;

endpackage

// [rtl/nthr_fwt.sv]
// Frame wait timer that flags when an extension request is due
`timescale 1ns/1ps
`include "nthr_params.svh"

module nthr_fwt (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic [19:0] limit,
    output wire logic        due
);

    logic [19:0] count;       // Cycles spent waiting since the timer started
    logic [20:0] count_ahead; // Count plus safety margin

    // Leave a margin so the extension leaves before the reader gives up
    assign count_ahead = {1'b0, count} + {1'b0, `NTHR_WTX_MARGIN};
    assign due         = run & (count_ahead >= {1'b0, limit});

    // Counting stops and clears whenever the sequencer is not waiting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 20'h00000;
        end
        else if (!run)
        begin
            count <= 20'h00000;
        end
        else if (count != 20'hfffff)
        begin
            count <= count + 20'h00001;
        end
    end

endmodule

// [tb/nthr_regs_checker.sv]
// Port-level assertions for the tag response parameter registers
`timescale 1ns/1ps
module nthr_regs_checker
    import nthr_pkg::*;
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [19:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire nthr_cmd_type    cmd,
    input wire nthr_answer_type answer,
    input wire logic            wtx_ack,
    input wire logic [19:0]     fwt_limit,
    input wire nthr_resp_type   resp,
    input wire nthr_wtx_type    wtx,
    input wire logic [15:0]     buffer_start
);
    logic busy; // Command in flight, rebuilt from the ports alone

    // Mirror of the sequencer: busy from an idle command to its answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy <= 1'b0;
        else if (!busy)
            busy <= cmd.valid;
        else if (answer.valid)
            busy <= 1'b0;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_update_load: assert property (cmd.valid && !busy && cmd.kind == NTHR_CMD_UPDATE
        |=> buffer_start == $past(cmd.store_index)) else $error("start index not loaded");
    chk_resp_after: assert property (busy && answer.valid |=> resp.valid)
        else $error("no status word after answer");
    chk_wtx_hold: assert property (wtx.valid && !wtx_ack && !answer.valid |=> wtx.valid)
        else $error("extension dropped early");
    chk_wtx_ack: assert property (wtx.valid && wtx_ack && !answer.valid |=> !wtx.valid)
        else $error("extension kept after ack");
    chk_wtx_early: assert property (cmd.valid && !busy && fwt_limit <= 20'd16
        ##1 !answer.valid |=> wtx.valid) else $error("short limit gave no extension");
    chk_idle_quiet: assert property (!busy |-> !wtx.valid)
        else $error("extension while idle");
endmodule

bind nthr_regs nthr_regs_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmd, .answer, .wtx_ack, .fwt_limit, .resp, .wtx,
    .buffer_start);

// [tb/nthr_host_model.sv]
// Host controller stand-in that finishes each reader command after a delay
`timescale 1ns/1ps
module nthr_host_model
    import nthr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] dly,
    input  wire logic       ok,
    output nthr_answer_type answer
);
    logic [7:0] left; // Cycles until the answer is handed over

    // Takes a command only while not counting, like the device's sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left   <= 8'h00;
            answer <= '0;
        end
        else
        begin
            answer.valid <= (left == 8'h01);
            answer.ok    <= ok;
            if (left != 8'h00)
                left <= left - 8'h01;
            else if (cmd_valid)
                left <= dly;
        end
    end
endmodule

// [tb/nthr_regs_tb.sv]
// Self-checking bench for the tag response parameter registers
`timescale 1ns/1ps
`include "nthr_params.svh"
module nthr_regs_tb
    import nthr_pkg::*;
;
    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [19:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    nthr_cmd_type    cmd;
    nthr_answer_type answer;
    logic            wtx_ack;
    logic [19:0]     fwt_limit;
    nthr_resp_type   resp;
    nthr_wtx_type    wtx;
    logic [15:0]     buffer_start;
    logic            host_ok;    // Outcome the host reports
    logic [7:0]      host_dly;   // Host handling time in cycles
    logic [15:0]     sw;         // Last status word seen
    logic [7:0]      wb;         // Last extension byte seen
    int              nw;         // Extensions asked in the last command
    logic [31:0]     r;          // Last read data
    logic            e;          // Last error flag
    int              n_mismatch;
    int              num_checks;

    nthr_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd, .answer, .wtx_ack, .fwt_limit, .resp, .wtx, .buffer_start);
    nthr_host_model host (.pclk, .presetn, .cmd_valid(cmd.valid), .dly(host_dly),
        .ok(host_ok), .answer);

    always #25 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [17:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A slave that never answers ends the run here
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Word as two byte registers, high byte at the next index
    task automatic rd16(input logic [17:0] lo, input logic [15:0] exp);
        logic [31:0] a;
        logic        ea;
        apb(1'b0, lo, 8'h00);
        a  = r;
        ea = e;
        apb(1'b0, lo + 18'd1, 8'h00);
        check({ea | e, r[22:0], a[7:0]}, {16'h0000, exp});
    endtask

    task automatic wr16(input logic [17:0] lo, input logic [15:0] v);
        apb(1'b1, lo, v[7:0]);
        apb(1'b1, lo + 18'd1, v[15:8]);
    endtask

    // One reader command; acks each extension once, then takes the status word
    task automatic run(input nthr_kind_type k, input logic [15:0] idx, input logic ok,
                       input logic [7:0] dly);
        int n;
        @(posedge pclk);
        host_ok  <= ok;
        host_dly <= dly;
        @(posedge pclk);
        cmd <= '{1'b1, k, idx};
        @(posedge pclk);
        cmd.valid <= 1'b0;
        nw = 0;
        n  = 0;
        while (resp.valid !== 1'b1 && n < 300)
        begin
            if (wtx.valid === 1'b1 && !wtx_ack)
            begin
                nw++;
                wb = wtx.wait_extension_byte;
            end
            wtx_ack <= (wtx.valid === 1'b1 && !wtx_ack);
            @(posedge pclk);
            n++;
        end
        wtx_ack <= 1'b0;
        sw = {resp.sw1, resp.sw2};
        // A command that never gets its status word ends the run here
        if (n >= 300)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 20'h00000;
        pwdata     = 32'h00000000;
        cmd        = '0;
        wtx_ack    = 1'b0;
        fwt_limit  = 20'd1000;
        host_ok    = 1'b1;
        host_dly   = 8'd4;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd16(`NTHR_IDX_CSW_LO, `NTHR_RST_CSW);
        rd16(`NTHR_IDX_WTX_LO, `NTHR_RST_WTX);
        rd16(`NTHR_IDX_BUF_LO, `NTHR_RST_BUF);
        rd16(`NTHR_IDX_VER_LO, `NTHR_VERSION);
        // Unmapped index is refused and reads zero
        apb(1'b0, 18'h00010, 8'h00);
        check({e, r[30:0]}, 32'h80000000);
        // Default words for every kind, fast answers need no extension
        for (int k = 0; k < 3; k++)
        begin
            run(nthr_kind_type'(k), 16'h0040, 1'b1, 8'd4);
            check(sw, `NTHR_SW_OK);
            check(nw, 0);
            run(nthr_kind_type'(k), 16'h0040, 1'b0, 8'd4);
            check(sw, `NTHR_SW_FAIL);
        end
        // Update loads the start index, a read leaves it, the host overwrites it
        run(NTHR_CMD_UPDATE, 16'h1234, 1'b1, 8'd4);
        rd16(`NTHR_IDX_BUF_LO, 16'h1234);
        run(NTHR_CMD_READ, 16'h0000, 1'b1, 8'd4);
        check(buffer_start, 16'h1234);
        wr16(`NTHR_IDX_BUF_LO, 16'h0567);
        @(posedge pclk);
        check(buffer_start, 16'h0567);
        // Custom word replaces the default whatever the outcome
        wr16(`NTHR_IDX_CSW_LO, 16'h6cf1);
        rd16(`NTHR_IDX_CSW_LO, 16'h6cf1);
        apb(1'b1, `NTHR_IDX_HOST_RESP, 8'h04);
        for (int k = 0; k < 3; k++)
        begin
            run(nthr_kind_type'(k), 16'h0000, k == 1, 8'd4);
            check(sw, 16'h6cf1);
        end
        // Other host bits set but enable clear gives the default back
        apb(1'b1, `NTHR_IDX_HOST_RESP, 8'hfb);
        run(NTHR_CMD_SELECT, 16'h0000, 1'b0, 8'd4);
        check(sw, `NTHR_SW_FAIL);
        // Host response bits read back; status shows idle with nothing pending
        apb(1'b0, `NTHR_IDX_HOST_RESP, 8'h00);
        check(r, 32'h000000fb);
        apb(1'b0, `NTHR_IDX_STATUS, 8'h00);
        check(r, 32'h00000000);
        // Slow host: extension byte sent, timer restarts after each ack
        fwt_limit <= 20'd8;
        run(NTHR_CMD_SELECT, 16'h0000, 1'b1, 8'd10);
        check(wb, 8'h01);
        wr16(`NTHR_IDX_WTX_LO, 16'h003c);
        rd16(`NTHR_IDX_WTX_LO, 16'h003c);
        fwt_limit <= 20'd20;
        run(NTHR_CMD_READ, 16'h0000, 1'b1, 8'd60);
        check(nw > 1, 1);
        check(wb, 8'h3c);
        check(sw, `NTHR_SW_OK);
        fwt_limit <= 20'd8;
        run(NTHR_CMD_SELECT, 16'h0000, 1'b1, 8'd10);
        check(nw > 0, 1);
        stop_test();
    end
endmodule
